/* logic/gdp_pkg.sv */
// What this block does
// RQ1: Reset address 26, accept 0 to 30
// RQ2: Controller avoids duplicate addresses, 0 or 21
// RQ3: Show address briefly after power-up when enabled
// RQ4: New address used at once by decoding
// RQ5: Receive ends on line feed or EOI
// RQ6: Send appends line feed with EOI
// RQ7: Talker active on talk address, idle otherwise
// RQ8: Listener active on listen address, idle otherwise
// RQ9: Remote lights lamp, locks most local keys
// RQ10: Service request lamp stays until conditions clear
// RQ11: Lamp follows summary, poll does not clear
// RQ12: Local key leaves remote, keys abort
// RQ13: Lockout ignores local key, output key works
// RQ14: Out-of-range address write rejected, kept
package gdp_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00; // Port enable
  localparam logic [7:0] ADDR_OFS   = 8'h04; // Primary address
  localparam logic [7:0] STAT_OFS   = 8'h08; // Bus state, read only
  localparam logic [7:0] ISTAT_OFS  = 8'h0C; // Event bits, write 1 clear
  localparam logic [7:0] IMASK_OFS  = 8'h10; // Event mask
  localparam logic [7:0] COND_OFS   = 8'h14; // Conditions, write clears all but events arriving that cycle
  localparam logic [7:0] SRQEN_OFS  = 8'h18; // Condition enables
  localparam logic [7:0] TX_OFS     = 8'h1C; // Byte to send
  localparam logic [7:0] RX_OFS     = 8'h20; // Received byte
  // Address limits and reset value
  localparam logic [4:0] ADDR_RESET = 5'h1A;
  localparam logic [4:0] ADDR_MAX   = 5'h1E;
  // Interface message bytes and the line feed terminator
  localparam logic [7:0] LISTEN_BASE = 8'h20;
  localparam logic [7:0] TALK_BASE   = 8'h40;
  localparam logic [7:0] CMD_UNL     = 8'h3F;
  localparam logic [7:0] CMD_UNT     = 8'h5F;
  localparam logic [7:0] CMD_LLO     = 8'h11;
  localparam logic [7:0] CMD_GTL     = 8'h01;
  localparam logic [7:0] LINE_FEED   = 8'h0A;
  // Event bit positions
  localparam int EV_RX_END = 0;
  localparam int EV_REJECT = 1;
  localparam int EV_ABORT  = 2;
  localparam int EV_TX_END = 3;
  localparam int EV_W      = 4;
  // Transmit and receive word fields
  localparam int TX_LAST_BIT = 8;
  localparam int RX_END_BIT  = 8;
  localparam int RX_VAL_BIT  = 9;
  // Address display time
  localparam int SHOW_MS     = 1000;
  localparam int CLK_KHZ     = 10000;
  localparam int SHOW_CYCLES = SHOW_MS * CLK_KHZ;
  // Transmit states
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_DATA = 3'b010,
    TX_TERM = 3'b100
  } gdp_tx_type;
endpackage

/* logic/gdp_port.sv */
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module gdp_port #(
  parameter int SHOW_COUNT = gdp_pkg::SHOW_CYCLES // Address display cycles
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // APB slave
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  // Bus interface messages, command bytes with ATN
  input  wire logic       bus_cmd_valid,
  input  wire logic [7:0] bus_cmd_byte,
  input  wire logic       bus_ifc,
  input  wire logic       bus_ren,
  input  wire logic       bus_serial_poll,
  // Bus data in
  input  wire logic       bus_rx_valid,
  input  wire logic [7:0] bus_rx_byte,
  input  wire logic       bus_rx_eoi,
  // Bus data out
  output logic            bus_tx_valid,
  output logic [7:0]      bus_tx_byte,
  output logic            bus_tx_eoi,
  input  wire logic       bus_tx_ready,
  // Front panel
  input  wire logic       local_key,
  input  wire logic       output_key,
  input  wire logic [7:0] status_event,
  output logic            host_control_lamp,
  output logic            talker_active_lamp,
  output logic            listener_active_lamp,
  output logic            srq_lamp,
  output logic            srq_request,
  output logic            show_addr,
  output logic [4:0]      show_addr_value,
  output logic            abort_pulse,
  output logic            irq
);
  // Matches a talk or listen address for the current address
  function automatic logic is_addr(input logic [7:0] b,
                                   input logic [7:0] base,
                                   input logic [4:0] a);
    is_addr = (b == (base | {3'h0, a}));
  endfunction
  // Register state
  logic        en_reg, en_next;           // Port enable
  logic [4:0]  addr_reg, addr_next;       // Primary address
  logic [gdp_pkg::EV_W-1:0] ist_reg, ist_next;     // Sticky events
  logic [gdp_pkg::EV_W-1:0] imask_reg, imask_next; // Event mask
  logic [7:0]  cond_reg, cond_next;       // Service conditions
  logic [7:0]  srqen_reg, srqen_next;     // Condition enables
  logic [9:0]  rx_reg, rx_next;           // Received byte word
  logic        tacs_reg, tacs_next;       // Talker active
  logic        lacs_reg, lacs_next;       // Listener active
  logic        rem_reg, rem_next;         // Remote state
  logic        llo_reg, llo_next;         // Local lockout
  logic        mss_reg, mss_next;         // Summary status
  logic        rqs_reg, rqs_next;         // Request for service
  logic        show_reg, show_next;       // Address display
  logic [31:0] show_cnt_reg, show_cnt_next;
  logic        abort_reg, abort_next;     // Abort pulse
  logic        irq_reg, irq_next;         // Interrupt line
  logic        rdy_reg, rdy_next;         // APB ready
  logic        err_reg, err_next;         // APB error
  logic [31:0] rd_reg, rd_next;           // APB read data
  // Transmit state
  gdp_pkg::gdp_tx_type tx_st_reg, tx_st_next;
  logic [7:0]  txb_reg, txb_next;         // Byte on the bus
  logic        txv_reg, txv_next;         // Byte valid
  logic        txe_reg, txe_next;         // EOI with byte
  logic        txl_reg, txl_next;         // Last byte of message
  // Bus strobes
  logic wr_go;  // Write takes effect
  logic rd_go;  // Read completes
  logic tx_wr;  // Write to transmit register
  logic tx_end; // Terminator accepted by the bus
  assign wr_go = psel & penable & rdy_reg & pwrite;
  assign rd_go = psel & penable & rdy_reg & ~pwrite;
  assign tx_wr = wr_go & (paddr == gdp_pkg::TX_OFS);
  // Register file, bus state and indicators
  always_comb begin
    logic stall;
    logic [gdp_pkg::EV_W-1:0] ev;
    logic [7:0] cb;
    stall = (paddr == gdp_pkg::TX_OFS) && pwrite &&
            (tx_st_reg != gdp_pkg::TX_IDLE);
    ev = '0;
    cb = bus_cmd_byte;
    en_next = en_reg;
    addr_next = addr_reg;
    imask_next = imask_reg;
    srqen_next = srqen_reg;
    cond_next = cond_reg | status_event;
    rx_next = rx_reg;
    tacs_next = tacs_reg;
    lacs_next = lacs_reg;
    rem_next = rem_reg;
    llo_next = llo_reg;
    rqs_next = rqs_reg;
    show_next = show_reg;
    show_cnt_next = show_cnt_reg;
    abort_next = output_key; // RQ12 RQ13
    err_next = 1'b0;
    rd_next = rd_reg;
    // Address display countdown after reset, only while enabled
    if (show_reg && en_reg && show_cnt_reg != 32'h0) begin
      show_cnt_next = show_cnt_reg - 32'h1;
    end else begin
      show_next = 1'b0; // RQ3
    end
    // Register writes
    if (wr_go) begin
      case (paddr)
        gdp_pkg::CTRL_OFS:  en_next = pwdata[0];
        gdp_pkg::ADDR_OFS: begin
          if (pwdata[31:0] <= {27'h0, gdp_pkg::ADDR_MAX}) begin
            addr_next = pwdata[4:0]; // RQ1 RQ4
          end else begin
            ev[gdp_pkg::EV_REJECT] = 1'b1; // RQ14
          end
        end
        gdp_pkg::IMASK_OFS: imask_next = pwdata[gdp_pkg::EV_W-1:0];
        gdp_pkg::COND_OFS:  cond_next = status_event; // RQ11
        gdp_pkg::SRQEN_OFS: srqen_next = pwdata[7:0];
        default: ;
      endcase
    end
    // Reading the receive word empties it
    rx_next[gdp_pkg::RX_VAL_BIT] = rx_reg[gdp_pkg::RX_VAL_BIT] &
                                   ~(rd_go && paddr == gdp_pkg::RX_OFS);
    // Incoming data while listener
    if (bus_rx_valid && lacs_reg) begin
      rx_next = {1'b1, 1'b0, bus_rx_byte};
      if (bus_rx_eoi || bus_rx_byte == gdp_pkg::LINE_FEED) begin
        rx_next[gdp_pkg::RX_END_BIT] = 1'b1; // RQ5
        ev[gdp_pkg::EV_RX_END] = 1'b1; // RQ5
      end
    end
    // Addressing commands, decoded against the live address
    if (bus_cmd_valid && en_reg) begin
      if (is_addr(cb, gdp_pkg::TALK_BASE, addr_reg)) begin
        tacs_next = 1'b1; // RQ7
        lacs_next = 1'b0; // RQ8
      end else if (is_addr(cb, gdp_pkg::LISTEN_BASE, addr_reg)) begin
        lacs_next = 1'b1; // RQ8
        tacs_next = 1'b0; // RQ7
        rem_next = rem_reg | bus_ren; // RQ9
      end else if (cb == gdp_pkg::CMD_UNT) begin
        tacs_next = 1'b0; // RQ7
      end else if (cb == gdp_pkg::CMD_UNL) begin
        lacs_next = 1'b0; // RQ8
      end else if (cb == gdp_pkg::CMD_LLO && bus_ren) begin
        llo_next = 1'b1; // RQ13
      end else if (cb == gdp_pkg::CMD_GTL && lacs_reg) begin
        rem_next = 1'b0;
      end
    end
    // Interface clear idles both roles
    if (bus_ifc) begin
      tacs_next = 1'b0; // RQ7
      lacs_next = 1'b0; // RQ8
    end
    // Front panel keys; the output key aborts even under lockout
    if (local_key && !llo_reg) begin
      rem_next = 1'b0; // RQ12 RQ13
      abort_next = 1'b1; // RQ12
    end
    ev[gdp_pkg::EV_ABORT] = abort_next;
    // Remote enable false returns to local and drops lockout
    if (!bus_ren) begin
      rem_next = 1'b0;
      llo_next = 1'b0;
    end
    ev[gdp_pkg::EV_TX_END] = tx_end;
    // Summary status follows enabled conditions
    mss_next = |(cond_next & srqen_reg); // RQ10 RQ11
    if (mss_next && !mss_reg) begin
      rqs_next = 1'b1;
    end else if (bus_serial_poll || !mss_next) begin
      rqs_next = 1'b0; // RQ11
    end
    // Sticky events: set wins over write-one clear
    ist_next = ist_reg;
    if (wr_go && paddr == gdp_pkg::ISTAT_OFS) begin
      ist_next = ist_reg & ~pwdata[gdp_pkg::EV_W-1:0];
    end
    ist_next = ist_next | ev;
    irq_next = |(ist_next & imask_next);
    // APB answer: one wait state, transmit write stalls while busy
    rdy_next = psel & penable & ~rdy_reg & ~stall;
    if (rdy_next) begin
      case (paddr)
        gdp_pkg::CTRL_OFS:  rd_next = {31'h0, en_reg};
        gdp_pkg::ADDR_OFS:  rd_next = {27'h0, addr_reg};
        gdp_pkg::STAT_OFS:  rd_next = {25'h0, txv_reg, mss_reg, rqs_reg,
                                       llo_reg, rem_reg, lacs_reg, tacs_reg};
        gdp_pkg::ISTAT_OFS: rd_next = {28'h0, ist_reg};
        gdp_pkg::IMASK_OFS: rd_next = {28'h0, imask_reg};
        gdp_pkg::COND_OFS:  rd_next = {24'h0, cond_reg};
        gdp_pkg::SRQEN_OFS: rd_next = {24'h0, srqen_reg};
        gdp_pkg::TX_OFS:    rd_next = 32'h0;
        gdp_pkg::RX_OFS:    rd_next = {22'h0, rx_reg};
        default: begin
          rd_next = 32'h0;
          err_next = 1'b1; // Unmapped address
        end
      endcase
    end
  end
  // Register file flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= 1'b1;
      addr_reg <= gdp_pkg::ADDR_RESET; // RQ1
      ist_reg <= '0;
      imask_reg <= '0;
      cond_reg <= 8'h00;
      srqen_reg <= 8'h00;
      rx_reg <= 10'h000;
      tacs_reg <= 1'b0;
      lacs_reg <= 1'b0;
      rem_reg <= 1'b0;
      llo_reg <= 1'b0;
      mss_reg <= 1'b0;
      rqs_reg <= 1'b0;
      show_reg <= 1'b1; // RQ3
      show_cnt_reg <= 32'(SHOW_COUNT);
      abort_reg <= 1'b0;
      irq_reg <= 1'b0;
      rdy_reg <= 1'b0;
      err_reg <= 1'b0;
      rd_reg <= 32'h0;
    end else begin
      en_reg <= en_next;
      addr_reg <= addr_next;
      ist_reg <= ist_next;
      imask_reg <= imask_next;
      cond_reg <= cond_next;
      srqen_reg <= srqen_next;
      rx_reg <= rx_next;
      tacs_reg <= tacs_next;
      lacs_reg <= lacs_next;
      rem_reg <= rem_next;
      llo_reg <= llo_next;
      mss_reg <= mss_next;
      rqs_reg <= rqs_next;
      show_reg <= show_next;
      show_cnt_reg <= show_cnt_next;
      abort_reg <= abort_next;
      irq_reg <= irq_next;
      rdy_reg <= rdy_next;
      err_reg <= err_next;
      rd_reg <= rd_next;
    end
  end
  // Transmit sequencer: data byte, then line feed with EOI when the last-byte bit is set
  always_comb begin
    tx_st_next = tx_st_reg;
    txb_next = txb_reg;
    txv_next = txv_reg;
    txe_next = txe_reg;
    txl_next = txl_reg;
    tx_end = 1'b0;
    case (tx_st_reg)
      gdp_pkg::TX_IDLE: begin
        if (tx_wr) begin
          txb_next = pwdata[7:0];
          txl_next = pwdata[gdp_pkg::TX_LAST_BIT];
          txv_next = 1'b1;
          tx_st_next = gdp_pkg::TX_DATA;
        end
      end
      gdp_pkg::TX_DATA: begin
        if (bus_tx_ready && tacs_reg) begin
          if (txl_reg) begin
            txb_next = gdp_pkg::LINE_FEED; // RQ6
            txe_next = 1'b1; // RQ6
            tx_st_next = gdp_pkg::TX_TERM;
          end else begin
            txv_next = 1'b0;
            tx_st_next = gdp_pkg::TX_IDLE;
          end
        end
      end
      gdp_pkg::TX_TERM: begin
        if (bus_tx_ready && tacs_reg) begin
          txv_next = 1'b0;
          txe_next = 1'b0;
          tx_end = 1'b1;
          tx_st_next = gdp_pkg::TX_IDLE;
        end
      end
      default: begin
        txv_next = 1'b0;
        txe_next = 1'b0;
        tx_st_next = gdp_pkg::TX_IDLE;
      end
    endcase
  end
  // Transmit flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_reg <= gdp_pkg::TX_IDLE;
      txb_reg <= 8'h00;
      txv_reg <= 1'b0;
      txe_reg <= 1'b0;
      txl_reg <= 1'b0;
    end else begin
      tx_st_reg <= tx_st_next;
      txb_reg <= txb_next;
      txv_reg <= txv_next;
      txe_reg <= txe_next;
      txl_reg <= txl_next;
    end
  end
  // Outputs straight from flip-flops
  assign prdata = rd_reg;
  assign pready = rdy_reg;
  assign pslverr = err_reg;
  assign bus_tx_valid = txv_reg;
  assign bus_tx_byte = txb_reg;
  assign bus_tx_eoi = txe_reg;
  assign host_control_lamp = rem_reg; // RQ9
  assign talker_active_lamp = tacs_reg; // RQ7
  assign listener_active_lamp = lacs_reg; // RQ8
  assign srq_lamp = mss_reg; // RQ10 RQ11
  assign srq_request = rqs_reg;
  assign show_addr = show_reg; // RQ3
  assign show_addr_value = addr_reg;
  assign abort_pulse = abort_reg;
  assign irq = irq_reg;
endmodule // gdp_port

/* tb/gdp_bus_model.sv */
`timescale 1ns/1ps
module gdp_bus_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Stall at random when high
  input  wire logic       slow,
  // Device data out
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_eoi,
  input  wire logic       talker,
  output logic            tx_ready,
  // Taken byte, EOI in bit 8
  output logic            got,
  output logic [8:0]      got_word
);
  // Take bytes as a listener would, promptly or slowly
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      got      <= 1'b0;
      got_word <= 9'h000;
    end else begin
      got      <= tx_valid && tx_ready && talker;
      got_word <= {tx_eoi, tx_byte};
      tx_ready <= slow ? 1'($urandom % 2) : 1'b1;
    end
  end
endmodule // gdp_bus_model

/* tb/gdp_port_sva.sv */
`timescale 1ns/1ps
module gdp_port_sva (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Bus side
  input wire logic       bus_cmd_valid,
  input wire logic [7:0] bus_cmd_byte,
  input wire logic       bus_ifc,
  input wire logic       bus_serial_poll,
  input wire logic       bus_tx_valid,
  input wire logic [7:0] bus_tx_byte,
  input wire logic       bus_tx_eoi,
  input wire logic       bus_tx_ready,
  // Panel side
  input wire logic       output_key,
  input wire logic       talker_active_lamp,
  input wire logic       listener_active_lamp,
  input wire logic       srq_lamp,
  input wire logic       abort_pulse,
  input wire logic [4:0] show_addr_value
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Own talk and listen codes at the current address
  wire logic [7:0] tk = gdp_pkg::TALK_BASE | {3'h0, show_addr_value};
  wire logic [7:0] ls = gdp_pkg::LISTEN_BASE | {3'h0, show_addr_value};
  wire logic       cv = bus_cmd_valid;
  talk_enter_a: assert property (cv && bus_cmd_byte == tk && !bus_ifc
    |=> talker_active_lamp) else $error("talker not entered");
  talk_leave_a: assert property (bus_ifc || cv &&
    (bus_cmd_byte == gdp_pkg::CMD_UNT || bus_cmd_byte == ls)
    |=> !talker_active_lamp) else $error("talker not left");
  listen_enter_a: assert property (cv && bus_cmd_byte == ls && !bus_ifc
    |=> listener_active_lamp) else $error("listener not entered");
  listen_leave_a: assert property (bus_ifc || cv &&
    (bus_cmd_byte == gdp_pkg::CMD_UNL || bus_cmd_byte == tk)
    |=> !listener_active_lamp) else $error("listener not left");
  tx_term_lf_a: assert property (bus_tx_valid && bus_tx_eoi
    |-> bus_tx_byte == gdp_pkg::LINE_FEED) else $error("eoi without lf");
  tx_hold_a: assert property (bus_tx_valid && !bus_tx_ready
    |=> bus_tx_valid && $stable({bus_tx_eoi, bus_tx_byte}))
    else $error("tx byte dropped");
  srq_poll_a: assert property (srq_lamp && bus_serial_poll
    |=> srq_lamp) else $error("poll cleared srq lamp");
  out_abort_a: assert property (output_key |=> abort_pulse)
    else $error("output key did not abort");
  addr_range_a: assert property (show_addr_value <= 5'h1E)
    else $error("address out of range");
endmodule // gdp_port_sva
bind gdp_port gdp_port_sva u_gdp_port_sva (
  .pclk(pclk), .presetn(presetn), .bus_cmd_valid(bus_cmd_valid),
  .bus_cmd_byte(bus_cmd_byte), .bus_ifc(bus_ifc),
  .bus_serial_poll(bus_serial_poll), .bus_tx_valid(bus_tx_valid),
  .bus_tx_byte(bus_tx_byte), .bus_tx_eoi(bus_tx_eoi),
  .bus_tx_ready(bus_tx_ready), .output_key(output_key),
  .talker_active_lamp(talker_active_lamp),
  .listener_active_lamp(listener_active_lamp), .srq_lamp(srq_lamp),
  .abort_pulse(abort_pulse), .show_addr_value(show_addr_value));

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  // Design inputs
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, bus_cmd_byte = 0, bus_rx_byte = 0;
  logic [7:0] status_event = 0, bus_tx_byte;
  logic [31:0] pwdata = 0, prdata;
  logic bus_cmd_valid = 0, bus_ifc = 0, bus_ren = 0, bus_rx_eoi = 0;
  logic bus_serial_poll = 0, bus_rx_valid = 0, local_key = 0;
  logic output_key = 0, slow = 0;
  // Design outputs
  logic pready, pslverr, bus_tx_ready, bus_tx_valid, bus_tx_eoi, irq;
  logic host_control_lamp, talker_active_lamp, listener_active_lamp;
  logic srq_lamp, srq_request, show_addr, abort_pulse, got;
  logic [4:0] show_addr_value, adr;
  logic [8:0] got_word;
  // Expected read words and sent bytes
  logic [32:0] rq[$];
  logic [8:0]  tq[$];
  int miscompares = 0, check_count = 0;
  localparam logic [7:0] AD = gdp_pkg::ADDR_OFS, ST = gdp_pkg::STAT_OFS;
  localparam logic [7:0] IS = gdp_pkg::ISTAT_OFS, IM = gdp_pkg::IMASK_OFS;
  // Command table and expected talker/listener bits
  logic [7:0] ops [10] = '{8'h40, 8'h20, 8'h40, 8'h5F, 8'h20,
                           8'h3F, 8'h40, 8'hFF, 8'h20, 8'hFF};
  logic [1:0] exs [10] = '{1, 2, 1, 0, 2, 0, 1, 0, 2, 0};

  gdp_port #(.SHOW_COUNT(8)) u_gdp_port (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_cmd_valid(bus_cmd_valid),
    .bus_cmd_byte(bus_cmd_byte), .bus_ifc(bus_ifc), .bus_ren(bus_ren),
    .bus_serial_poll(bus_serial_poll), .bus_rx_valid(bus_rx_valid),
    .bus_rx_byte(bus_rx_byte), .bus_rx_eoi(bus_rx_eoi),
    .bus_tx_valid(bus_tx_valid), .bus_tx_byte(bus_tx_byte),
    .bus_tx_eoi(bus_tx_eoi), .bus_tx_ready(bus_tx_ready),
    .local_key(local_key), .output_key(output_key),
    .status_event(status_event), .host_control_lamp(host_control_lamp),
    .talker_active_lamp(talker_active_lamp),
    .listener_active_lamp(listener_active_lamp), .srq_lamp(srq_lamp),
    .srq_request(srq_request), .show_addr(show_addr),
    .show_addr_value(show_addr_value), .abort_pulse(abort_pulse),
    .irq(irq));
  gdp_bus_model u_gdp_bus_model (.pclk(pclk), .presetn(presetn),
    .slow(slow), .tx_valid(bus_tx_valid), .tx_byte(bus_tx_byte),
    .tx_eoi(bus_tx_eoi), .talker(talker_active_lamp),
    .tx_ready(bus_tx_ready), .got(got), .got_word(got_word));

  always #50 pclk = ~pclk;

  // Verdict and end of run
  task automatic summarize;
    if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // One APB transfer; reads note the expected word
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [32:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d[31:0];
    if (!w) rq.push_back(d);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (!pready && n < 40);
    if (!pready) begin miscompares++; summarize(); end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, {1'b0, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, {1'b0, d});
  endtask
  // Command byte pulse; FF stands for interface clear
  task automatic cmd(input logic [7:0] b);
    @(posedge pclk);
    bus_cmd_valid <= (b != 8'hFF);
    bus_ifc <= (b == 8'hFF);
    bus_cmd_byte <= b;
    @(posedge pclk);
    bus_cmd_valid <= 1'b0;
    bus_ifc <= 1'b0;
  endtask
  // Data byte in, then read it back with its end flag
  task automatic rx(input logic [7:0] b, input logic e);
    @(posedge pclk);
    bus_rx_valid <= 1'b1;
    bus_rx_byte <= b;
    bus_rx_eoi <= e;
    @(posedge pclk);
    bus_rx_valid <= 1'b0;
    rd(gdp_pkg::RX_OFS, {22'h0, 1'b1, b == 8'h0A || e, b});
  endtask
  // Key pulse and the abort it should give
  task automatic key(input logic loc, input logic ab);
    @(posedge pclk);
    local_key <= loc;
    output_key <= !loc;
    @(posedge pclk);
    local_key <= 1'b0;
    output_key <= 1'b0;
    @(posedge pclk);
    chk(abort_pulse, ab);
  endtask

  // Read data and sent bytes against the notes
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite)
      chk({pslverr, prdata}, rq.pop_front());
    if (got) chk(got_word, tq.pop_front());
  end

  // Main sequence
  initial begin
    void'($urandom(32'h7EF1));
    repeat (20) @(posedge pclk);
    chk(show_addr_value, 5'h1A);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(show_addr, 1'b1);
    repeat (10) @(posedge pclk);
    chk(show_addr, 1'b0);
    rd(AD, 32'h1A);
    apb(1'b0, 8'h40, 33'h1_0000_0000);
    wr(AD, 32'h1F);
    rd(AD, 32'h1A);
    rd(IS, 32'h2);
    for (int i = 0; i < 4; i++) begin
      adr = 5'($urandom % 31);
      if (adr == 5'h00 || adr == 5'h15 || i == 3) adr = 5'h1E;
      wr(AD, {27'h0, adr});
      rd(AD, {27'h0, adr});
      chk(show_addr_value, adr);
    end
    foreach (ops[i]) begin
      cmd(ops[i] == 8'h40 || ops[i] == 8'h20 ? ops[i] | adr : ops[i]);
      rd(ST, {30'h0, exs[i]});
      chk({listener_active_lamp, talker_active_lamp}, exs[i]);
    end
    cmd(8'h3E);
    rx(8'h41, 1'b0);
    rx(8'h0A, 1'b0);
    rx(8'h42, 1'b1);
    wr(IS, 32'hF);
    wr(IM, 32'h8);
    cmd(8'h5E);
    slow <= 1'b1;
    tq = '{9'h048, 9'h049, 9'h10A};
    wr(gdp_pkg::TX_OFS, 32'h048);
    wr(gdp_pkg::TX_OFS, 32'h149);
    repeat (300) if (tq.size() != 0) @(posedge pclk);
    if (tq.size() != 0) begin miscompares++; summarize(); end
    rd(IS, 32'h8);
    chk(irq, 1'b1);
    wr(IM, 32'h0);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
    wr(IM, 32'h8);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b1);
    wr(IS, 32'h8);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
    bus_ren <= 1'b1;
    cmd(8'h3E);
    rd(ST, 32'h6);
    chk(host_control_lamp, 1'b1);
    key(1'b1, 1'b1);
    rd(ST, 32'h2);
    chk(host_control_lamp, 1'b0);
    cmd(8'h3E);
    cmd(gdp_pkg::CMD_LLO);
    rd(ST, 32'hE);
    key(1'b1, 1'b0);
    rd(ST, 32'hE);
    key(1'b0, 1'b1);
    cmd(gdp_pkg::CMD_GTL);
    rd(ST, 32'hA);
    chk(host_control_lamp, 1'b0);
    bus_ren <= 1'b0;
    wr(gdp_pkg::SRQEN_OFS, 32'h1);
    status_event <= 8'h01;
    @(posedge pclk);
    status_event <= 8'h00;
    rd(ST, 32'h32);
    chk({srq_lamp, srq_request}, 2'h3);
    bus_serial_poll <= 1'b1;
    @(posedge pclk);
    bus_serial_poll <= 1'b0;
    rd(ST, 32'h22);
    chk({srq_lamp, srq_request}, 2'h2);
    wr(gdp_pkg::COND_OFS, 32'h0);
    rd(ST, 32'h02);
    chk(srq_lamp, 1'b0);
    summarize();
  end
endmodule // testbench
